//--- src/gcfg_pkg.sv
package gcfg_pkg;

  // Register indices; bit 7 of the address byte marks a write
  localparam logic [6:0] IDX_GLOBAL_CONFIG   = 7'h00;
  localparam logic [6:0] IDX_STATUS_FLAGS    = 7'h01;
  localparam logic [6:0] IDX_WRITE_COUNTER   = 7'h02;
  localparam logic [6:0] IDX_REPLY_CONFIG    = 7'h03;
  localparam logic [6:0] IDX_FUSE_PROGRAM    = 7'h04;
  localparam logic [6:0] IDX_FUSE_READBACK   = 7'h05;
  localparam int         ADDR_WRITE_BIT      = 7;

  // Global configuration fields
  localparam int          CFG_W              = 10;
  localparam int          CFG_USTEP_SRC_BIT  = 7;
  localparam int          CFG_STEP_FILT_BIT  = 8;
  localparam int          CFG_TEST_MODE_BIT  = 9;
  localparam logic [9:0]  CFG_RESET          = 10'h100;

  // Status flag positions
  localparam int          ST_RESET_BIT       = 0;
  localparam int          ST_DRV_ERR_BIT     = 1;
  localparam int          ST_PUMP_UV_BIT     = 2;

  // Reply configuration field
  localparam int          REPLY_LSB          = 8;
  localparam int          REPLY_MSB          = 11;
  localparam int          BITS_PER_UNIT      = 8;

  // Fuse programming fields
  localparam int          FUSE_BIT_LSB       = 0;
  localparam int          FUSE_BYTE_LSB      = 4;
  localparam int          FUSE_MAGIC_LSB     = 8;
  localparam logic [7:0]  FUSE_MAGIC         = 8'hbd;
  localparam int          FUSE_W             = 24;

  // One decoded, CRC-checked datagram from the serial front end
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
  } acc_req_t;

  // Fuse programming request
  typedef struct packed {
    logic       strobe;
    logic [1:0] byte_sel;
    logic [2:0] bit_sel;
  } fuse_prog_t;

  // Reply timer states
  typedef enum logic [1:0] {
    RT_IDLE = 2'b01,
    RT_WAIT = 2'b10
  } reply_state_t;

endpackage : gcfg_pkg

//--- src/stepper_general_config_regs.sv
`timescale 1ns/1ps
// Overview of operation
// R1: Config bit 8 (reset 1) enables step filtering above about 750Hz fullstep and the filtered period readout.
// R2: Config bit 9 drives the test output on the enable pin, drops its pull-down and treats the driver as enabled.
// R3: With the microstep source flag at 1 the resolution comes from the register setting instead of the pins.
// R4: A status flag is cleared only by writing 1 to its bit; writing 0 leaves it alone.
// R5: Status bit 0 is set after any reset, when all registers hold reset values, and stays until cleared.
// R6: Status bit 1 is set whenever the power stage is shut down for overtemperature or short circuit.
// R7: Clearing the driver fault flag is ignored while any of its error conditions is still present.
// R8: Status bit 2 follows charge pump undervoltage without latching and the power stage is off while it is set.
// R9: An 8-bit counter increments once for every successfully received write access.
// R10: Reading the counter leaves it unchanged and an increment from 255 wraps to 0.
// R11: The 4-bit reply delay gives 8 bit times for 0 and 1, adding 16 bit times per pair, up to 15*8 for 14 and 15.
// R12: Each write to the fuse programming register programs exactly one fuse bit; the code programs none unless bits 15:8 hold the key 8'hbd.
// R13: A read access after a programming write refreshes the fuse readback data.
// R14: Address bit 7 set marks a write; addresses without it are reads.
// R15: Every register resets to 0 unless another reset value is given.
// R16: The reply delay runs from the end of the request stop bit, in bit times of the detected baud rate.
module stepper_general_config_regs
  import gcfg_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          sys_rst_i,
  // Decoded datagram access from the serial front end
  input  wire acc_req_t      acc_i,
  output logic [31:0]        rd_data_o,
  output logic               rd_valid_o,
  // Reply timing
  input  wire logic          req_stop_end_i,
  input  wire logic [15:0]   bit_cycles_i,
  output logic               reply_go_o,
  // Driver status inputs
  input  wire logic          drv_shutdown_i,
  input  wire logic          drv_err_cond_i,
  input  wire logic          pump_undervoltage_flag_i,
  input  wire logic          enable_input_low_i,
  // Microstep and step period sources
  input  wire logic [3:0]    pin_mres_i,
  input  wire logic [3:0]    reg_mres_i,
  input  wire logic [19:0]   step_period_raw_i,
  input  wire logic [19:0]   step_period_filt_i,
  // Fuse memory
  input  wire logic [23:0]   fuse_mem_i,
  output fuse_prog_t         fuse_prog_o,
  // Driver control outputs
  output logic               step_filter_en_o,
  output logic [19:0]        step_period_readout_o,
  output logic               test_out_en_o,
  output logic               enable_pulldown_en_o,
  output logic               drv_enabled_o,
  output logic               power_stage_en_o,
  output logic [3:0]         microstep_res_o
);

  // Reply length in bit times: odd-rounded code times eight
  function automatic logic [6:0] reply_bits(input logic [3:0] code);
    reply_bits = 7'(({3'h0, code} | 7'h01) * BITS_PER_UNIT);
  endfunction : reply_bits

  // Access decode
  wire        wr_acc    = acc_i.valid &  acc_i.addr[ADDR_WRITE_BIT]; // R14
  wire        rd_acc    = acc_i.valid & ~acc_i.addr[ADDR_WRITE_BIT]; // R14
  wire [6:0]  idx       = acc_i.addr[6:0];
  wire        wr_cfg    = wr_acc && (idx == IDX_GLOBAL_CONFIG);
  wire        wr_stat   = wr_acc && (idx == IDX_STATUS_FLAGS);
  wire        wr_reply  = wr_acc && (idx == IDX_REPLY_CONFIG);
  wire        wr_fuse   = wr_acc && (idx == IDX_FUSE_PROGRAM)
                          && (acc_i.data[FUSE_MAGIC_LSB +: 8] == FUSE_MAGIC);

  logic [CFG_W-1:0]  cfg_ff;
  logic              rst_flag_ff;
  logic              drv_err_ff;
  logic [7:0]        cnt_ff;
  logic [3:0]        reply_wait_field_ff;
  logic              fuse_stale_ff;
  logic [FUSE_W-1:0] fuse_rd_ff;
  reply_state_t      rt_state_ff;
  logic [15:0]       cyc_ff;
  logic [6:0]        bits_ff;

  // Status flag next values; hardware set beats a software clear
  wire clr_rst    = wr_stat && acc_i.data[ST_RESET_BIT];                    // R4
  wire clr_drv    = wr_stat && acc_i.data[ST_DRV_ERR_BIT] && !drv_err_cond_i; // R7
  wire nxt_drv_err = drv_shutdown_i | (drv_err_ff & ~clr_drv);              // R6
  wire [2:0] status_view = {pump_undervoltage_flag_i, drv_err_ff, rst_flag_ff}; // R8

  // Fuse readback: a stale copy is replaced on the read that follows programming
  wire                refresh   = rd_acc && fuse_stale_ff;                  // R13
  wire [FUSE_W-1:0]   fuse_view = refresh ? fuse_mem_i : fuse_rd_ff;

  // Read multiplexer; write-only and unmapped locations read as zero
  logic [31:0] nxt_rd_data;
  always_comb begin
    if (idx == IDX_GLOBAL_CONFIG) begin
      nxt_rd_data = {22'h0, cfg_ff};
    end else if (idx == IDX_STATUS_FLAGS) begin
      nxt_rd_data = {29'h0, status_view};
    end else if (idx == IDX_WRITE_COUNTER) begin
      nxt_rd_data = {24'h0, cnt_ff};
    end else if (idx == IDX_FUSE_READBACK) begin
      nxt_rd_data = {8'h0, fuse_view};
    end else begin
      nxt_rd_data = 32'h0;
    end
  end

  // Configuration, counter and reply field
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cfg_ff              <= CFG_RESET;   // R15
      cnt_ff              <= 8'h00;
      reply_wait_field_ff <= 4'h0;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= acc_i.data[CFG_W-1:0];
      end
      if (wr_acc) begin
        cnt_ff <= cnt_ff + 8'h01;          // R9 R10
      end
      if (wr_reply) begin
        reply_wait_field_ff <= acc_i.data[REPLY_MSB:REPLY_LSB];
      end
    end
  end

  // Sticky status flags
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rst_flag_ff <= 1'b1;                 // R5
      drv_err_ff  <= 1'b0;
    end else begin
      rst_flag_ff <= rst_flag_ff & ~clr_rst;
      drv_err_ff  <= nxt_drv_err;
    end
  end

  // Read answer and fuse access; only one fuse bit per write
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_data_o     <= 32'h0;
      rd_valid_o    <= 1'b0;
      fuse_stale_ff <= 1'b1;               // First read loads the readback copy
      fuse_rd_ff    <= '0;
      fuse_prog_o   <= '0;
    end else begin
      rd_valid_o           <= rd_acc;
      fuse_prog_o.strobe   <= wr_fuse;     // R12
      if (rd_acc) begin
        rd_data_o <= nxt_rd_data;
      end
      if (wr_fuse) begin
        fuse_prog_o.byte_sel <= acc_i.data[FUSE_BYTE_LSB +: 2];
        fuse_prog_o.bit_sel  <= acc_i.data[FUSE_BIT_LSB +: 3];
      end
      if (refresh) begin
        fuse_rd_ff <= fuse_mem_i;
      end
      fuse_stale_ff <= wr_fuse | (fuse_stale_ff & ~rd_acc); // R13
    end
  end

  // Reply timer: bit_cycles_i must be at least 1
  wire [15:0] cyc_load = bit_cycles_i - 16'h0001;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rt_state_ff <= RT_IDLE;
      cyc_ff      <= 16'h0;
      bits_ff     <= 7'h0;
      reply_go_o  <= 1'b0;
    end else begin
      reply_go_o <= 1'b0;
      case (rt_state_ff)
        RT_IDLE: begin
          if (req_stop_end_i) begin        // R16
            rt_state_ff <= RT_WAIT;
            cyc_ff      <= cyc_load;
            bits_ff     <= reply_bits(reply_wait_field_ff) - 7'h01; // R11
          end
        end
        RT_WAIT: begin
          if (cyc_ff != 16'h0) begin
            cyc_ff <= cyc_ff - 16'h0001;
          end else if (bits_ff != 7'h0) begin
            bits_ff <= bits_ff - 7'h01;
            cyc_ff  <= cyc_load;
          end else begin
            rt_state_ff <= RT_IDLE;
            reply_go_o  <= 1'b1;
          end
        end
        default: rt_state_ff <= RT_IDLE;
      endcase
    end
  end

  // Driver control; test mode forces enable since the pin carries the test signal
  assign step_filter_en_o      = cfg_ff[CFG_STEP_FILT_BIT];                                   // R1
  assign step_period_readout_o = step_filter_en_o ? step_period_filt_i : step_period_raw_i;   // R1
  assign test_out_en_o         = cfg_ff[CFG_TEST_MODE_BIT];                                   // R2
  assign enable_pulldown_en_o  = ~cfg_ff[CFG_TEST_MODE_BIT];                                  // R2
  assign drv_enabled_o         = cfg_ff[CFG_TEST_MODE_BIT] | ~enable_input_low_i;             // R2
  assign power_stage_en_o      = drv_enabled_o & ~pump_undervoltage_flag_i;                   // R8
  assign microstep_res_o       = cfg_ff[CFG_USTEP_SRC_BIT] ? reg_mres_i : pin_mres_i;         // R3

  // Checking helpers: cycles from request stop to reply
  logic [23:0] sva_cnt_ff;
  logic [23:0] sva_exp_ff;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sva_cnt_ff <= 24'h0;
      sva_exp_ff <= 24'h0;
    end else if (rt_state_ff == RT_IDLE) begin
      sva_cnt_ff <= 24'h0;
      // Worked out apart from the timer function, at full width so large baud counts do not wrap
      sva_exp_ff <= 24'({reply_wait_field_ff[3:1], 1'b1}) * 24'(BITS_PER_UNIT) * 24'(bit_cycles_i);
    end else begin
      sva_cnt_ff <= sva_cnt_ff + 24'h000001;
    end
  end

  sequence s_fuse_write;
    wr_fuse;
  endsequence
  sequence s_one_strobe;
    fuse_prog_o.strobe ##1 !fuse_prog_o.strobe;
  endsequence

  a_filter_select: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R1
    step_period_readout_o == (cfg_ff[8] ? step_period_filt_i : step_period_raw_i))
    else $error("step period readout source wrong");
  a_test_mode_pin: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R2
    cfg_ff[9] |-> (test_out_en_o && !enable_pulldown_en_o && drv_enabled_o))
    else $error("test mode pin handling wrong");
  a_mres_source: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R3
    cfg_ff[7] |-> microstep_res_o == reg_mres_i)
    else $error("microstep source not the register");
  a_w1c_zero_keep: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R4
    (rst_flag_ff && !(wr_stat && acc_i.data[0])) |=> rst_flag_ff)
    else $error("reset flag lost without a 1 write");
  a_reset_flag_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R5
    $fell(sys_rst_i) |-> (rst_flag_ff && cfg_ff == 10'h100 && cnt_ff == 8'h00))
    else $error("reset state wrong after release");
  a_drv_err_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R6
    drv_shutdown_i |=> status_view[1])
    else $error("shutdown did not set driver fault");
  a_drv_err_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R7
    (drv_err_ff && drv_err_cond_i) |=> drv_err_ff)
    else $error("driver fault cleared while condition present");
  a_uv_power_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R8
    pump_undervoltage_flag_i |-> (!power_stage_en_o && status_view[2]))
    else $error("power stage on during undervoltage");
  a_counter_step: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R9
    wr_acc |=> cnt_ff == 8'($past(cnt_ff) + 8'h01))
    else $error("write counter did not step");
  a_counter_read_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R10
    !wr_acc |=> $stable(cnt_ff))
    else $error("write counter changed without a write");
  a_reply_delay: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R11
    reply_go_o |-> sva_cnt_ff == sva_exp_ff)
    else $error("reply delay length wrong");
  a_reply_start: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R16
    (req_stop_end_i && rt_state_ff == RT_IDLE) |=> rt_state_ff == RT_WAIT)
    else $error("reply timer did not start at stop end");
  a_fuse_one_bit: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R12
    s_fuse_write |=> s_one_strobe)
    else $error("fuse write did not give one program strobe");
  a_fuse_refresh: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R13
    (s_fuse_write ##[1:8] rd_acc) |=> fuse_rd_ff == $past(fuse_mem_i))
    else $error("fuse readback not refreshed");

endmodule : stepper_general_config_regs

//--- dv/uart_host_model.sv
`timescale 1ns/1ps
// Host side of the decoded serial link; one datagram per call
module uart_host_model
  import gcfg_pkg::*;
(
  // Clock
  input  wire logic  sys_clk_i,
  // Toward the register bank
  output acc_req_t   acc_o,
  output logic       stop_end_o
);
  initial begin
    acc_o      = '0;
    stop_end_o = 1'b0;
  end

  // Held one cycle, then dropped with scrambled fields so stale data is never trusted
  task automatic send(input logic [7:0] addr, input logic [31:0] data);
    @(posedge sys_clk_i);
    acc_o <= '{valid: 1'b1, addr: addr, data: data};
    @(posedge sys_clk_i);
    acc_o <= '{valid: 1'b0, addr: ~addr, data: ~data};
  endtask : send

  task automatic wr(input logic [6:0] idx, input logic [31:0] data);
    send({1'b1, idx}, data);
  endtask : wr

  task automatic rd(input logic [6:0] idx);
    send({1'b0, idx}, 32'h0);
  endtask : rd

  // Pulse at the end of a request's stop bit
  task automatic stop_end();
    @(posedge sys_clk_i);
    stop_end_o <= 1'b1;
    @(posedge sys_clk_i);
    stop_end_o <= 1'b0;
  endtask : stop_end
endmodule : uart_host_model

//--- dv/test_stepper_general_config_regs.sv
`timescale 1ns/1ps
// Reads are scored against a queue of expected words; the rest is checked in place
module test_stepper_general_config_regs;
  import gcfg_pkg::*;
  // Design inputs and outputs
  logic        sys_clk_i, sys_rst_i, req_stop_end_i, drv_shutdown_i, drv_err_cond_i;
  logic        pump_undervoltage_flag_i, enable_input_low_i, rd_valid_o, reply_go_o;
  logic        step_filter_en_o, test_out_en_o, enable_pulldown_en_o, drv_enabled_o, power_stage_en_o;
  logic [3:0]  pin_mres_i, reg_mres_i, microstep_res_o;
  logic [15:0] bit_cycles_i, seed, bc;
  logic [19:0] step_period_raw_i, step_period_filt_i, step_period_readout_o;
  logic [23:0] fuse_mem_i, fm;
  logic [31:0] rd_data_o;
  logic [31:0] exp_q[$];
  logic [9:0]  cfg;
  logic [7:0]  cnt;
  acc_req_t    acc_i;
  fuse_prog_t  fuse_prog_o;
  int          error_cnt, n_tests, k, st;
  logic [9:0]  cfgs[5] = '{10'h000, 10'h080, 10'h100, 10'h200, 10'h380};

  uart_host_model host (.sys_clk_i(sys_clk_i), .acc_o(acc_i), .stop_end_o(req_stop_end_i));

  stepper_general_config_regs dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .acc_i(acc_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .req_stop_end_i(req_stop_end_i), .bit_cycles_i(bit_cycles_i),
    .reply_go_o(reply_go_o), .drv_shutdown_i(drv_shutdown_i), .drv_err_cond_i(drv_err_cond_i),
    .pump_undervoltage_flag_i(pump_undervoltage_flag_i), .enable_input_low_i(enable_input_low_i),
    .pin_mres_i(pin_mres_i), .reg_mres_i(reg_mres_i), .step_period_raw_i(step_period_raw_i),
    .step_period_filt_i(step_period_filt_i), .fuse_mem_i(fuse_mem_i), .fuse_prog_o(fuse_prog_o),
    .step_filter_en_o(step_filter_en_o), .step_period_readout_o(step_period_readout_o),
    .test_out_en_o(test_out_en_o), .enable_pulldown_en_o(enable_pulldown_en_o),
    .drv_enabled_o(drv_enabled_o), .power_stage_en_o(power_stage_en_o),
    .microstep_res_o(microstep_res_o)
  );

  // 50 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // Counter model follows every write, whatever the index
  task automatic wr(input logic [6:0] idx, input logic [31:0] data);
    host.wr(idx, data);
    cnt++;
  endtask : wr

  task automatic rd(input logic [6:0] idx, input logic [31:0] exp);
    exp_q.push_back(exp);
    host.rd(idx);
  endtask : rd

  // Driver control outputs against the config word and live inputs
  task automatic chk_out();
    logic drv;
    #1;
    drv = cfg[9] | !enable_input_low_i;
    check("ctrl", {3'h0, cfg[9], !cfg[9], drv, drv & !pump_undervoltage_flag_i, cfg[8],
      cfg[7] ? reg_mres_i : pin_mres_i, cfg[8] ? step_period_filt_i : step_period_raw_i},
      {3'h0, test_out_en_o, enable_pulldown_en_o, drv_enabled_o, power_stage_en_o, step_filter_en_o,
      microstep_res_o, step_period_readout_o});
  endtask : chk_out

  // Counts strobe pulses over a short window after a fuse write
  task automatic fuse_watch(input logic [31:0] n);
    st = 0;
    repeat (3) begin
      #1;
      if (fuse_prog_o.strobe === 1'b1) st++;
      @(posedge sys_clk_i);
    end
    check("fuse_strobes", n, 32'(st));
  endtask : fuse_watch

  // Read answers are taken in order of request
  always @(posedge sys_clk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check("rd_count", 32'h1, 32'h0);
      else check("rd_data", exp_q.pop_front(), rd_data_o);
    end
  end

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    error_cnt++;
    complete_run();
  end

  initial begin
    {sys_rst_i, drv_shutdown_i, drv_err_cond_i, pump_undervoltage_flag_i} = 4'h8;
    {enable_input_low_i, pin_mres_i, reg_mres_i} = 9'h123;
    {bit_cycles_i, step_period_raw_i, step_period_filt_i} = {16'h1, 20'h12345, 20'h0abcd};
    seed = 16'h0e39;
    fm = 24'h3c5a69;
    fuse_mem_i = fm;
    cnt = 8'h0;
    cfg = CFG_RESET;
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    chk_out();
    rd(IDX_STATUS_FLAGS, 32'h1);
    rd(IDX_GLOBAL_CONFIG, {22'h0, CFG_RESET});
    rd(IDX_WRITE_COUNTER, 32'h0);
    wr(IDX_STATUS_FLAGS, 32'h0);
    rd(IDX_STATUS_FLAGS, 32'h1);
    wr(IDX_STATUS_FLAGS, 32'h1);
    rd(IDX_STATUS_FLAGS, 32'h0);
    // Fault with its cause still present, then gone
    drv_shutdown_i <= 1'b1;
    drv_err_cond_i <= 1'b1;
    @(posedge sys_clk_i);
    drv_shutdown_i <= 1'b0;
    rd(IDX_STATUS_FLAGS, 32'h2);
    wr(IDX_STATUS_FLAGS, 32'h2);
    rd(IDX_STATUS_FLAGS, 32'h2);
    drv_err_cond_i <= 1'b0;
    wr(IDX_STATUS_FLAGS, 32'h2);
    rd(IDX_STATUS_FLAGS, 32'h0);
    pump_undervoltage_flag_i <= 1'b1;
    rd(IDX_STATUS_FLAGS, 32'h4);
    chk_out();
    // Each config mode with random pin and register inputs
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      {enable_input_low_i, pump_undervoltage_flag_i, reg_mres_i, pin_mres_i} <= seed[9:0];
      step_period_raw_i <= {seed, 4'h1};
      step_period_filt_i <= {~seed, 4'h2};
      cfg = cfgs[i];
      wr(IDX_GLOBAL_CONFIG, {22'h0, cfg});
      chk_out();
      rd(IDX_GLOBAL_CONFIG, {22'h0, cfg});
    end
    // Refused and unmapped writes still count; run past the wrap
    wr(IDX_WRITE_COUNTER, 32'hff);
    repeat (250) wr(7'h10, {16'h0, seed});
    rd(IDX_WRITE_COUNTER, {24'h0, cnt});
    rd(IDX_WRITE_COUNTER, {24'h0, cnt});
    rd(7'h10, 32'h0);
    // Reply wait for every field code
    for (int f = 0; f < 16; f++) begin
      seed = lfsr(seed);
      bc = {14'h0, seed[1:0]} + 16'h1;
      bit_cycles_i <= bc;
      wr(IDX_REPLY_CONFIG, 32'(f) << REPLY_LSB);
      host.stop_end();
      k = 0;
      #1;
      while (reply_go_o !== 1'b1 && k < 2000) begin
        @(posedge sys_clk_i);
        #1;
        k++;
      end
      check("reply_wait", 32'((f | 1) * 8 * bc), 32'(k));
    end
    rd(IDX_REPLY_CONFIG, 32'h0);
    // Fuse programming: bad key refused, good key strobes once, then readback refresh
    rd(IDX_FUSE_READBACK, {8'h0, fm});
    wr(IDX_FUSE_PROGRAM, 32'h00be25);
    fuse_watch(32'h0);
    wr(IDX_FUSE_PROGRAM, {16'h0, FUSE_MAGIC, 8'h25});
    fuse_watch(32'h1);
    check("fuse_sel", 32'h15, {27'h0, fuse_prog_o.byte_sel, fuse_prog_o.bit_sel});
    fm = {seed, 8'ha5};
    fuse_mem_i <= fm;
    rd(IDX_FUSE_READBACK, {8'h0, fm});
    repeat (4) @(posedge sys_clk_i);
    check("pending_reads", 32'h0, 32'(exp_q.size()));
    complete_run();
  end
endmodule : test_stepper_general_config_regs
